// >>> logic/mpc_consts.svh
`ifndef MPC_CONSTS_SVH
`define MPC_CONSTS_SVH

// clock and reset stretch timing
`define MPC_CLK_PERIOD_PS     25000
`define MPC_STRETCH_TIME_NS   258000
`define MPC_STRETCH_CYCLES    ((`MPC_STRETCH_TIME_NS * 1000) / `MPC_CLK_PERIOD_PS)

// indicator select field: two bits per pin
`define MPC_IND_SEL_W         2
`define MPC_IND_SEL_RESET     6'h24
`define MPC_IND_NUM           3

`endif

// >>> logic/mpc_pin_ctrl.sv
`timescale 1ns/10ps
`include "mpc_consts.svh"
module mpc_pin_ctrl
  import mpc_pkg::*;
#(
  parameter int STRETCH_CYCLES = `MPC_STRETCH_CYCLES,
  parameter int SCAN_LEN       = 8
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // mode requests
  input  wire logic                    reset_n_pin_i,
  input  wire logic                    soft_reset_i,
  input  wire logic                    powerdown_pin_i,
  input  wire logic                    soft_powerdown_i,
  input  wire logic                    isolate_i,
  input  wire logic                    sleep_i,
  // core side mii data
  input  wire mpc_rx_s                 core_rx_i,
  input  wire logic                    core_tx_clk_i,
  input  wire logic                    core_rx_clk_i,
  // mii outputs to the mac
  output mpc_rx_s                      mii_rx_o,
  output logic                         mii_tx_clk_o,
  output logic                         mii_rx_clk_o,
  output mpc_drive_s                   mii_out_drv_o,
  output mpc_drive_s                   mii_in_drv_o,
  output mpc_mode_e                    mode_o,
  // indicators
  input  wire logic [`MPC_IND_SEL_W*`MPC_IND_NUM-1:0] ind_sel_i,
  input  wire mpc_status_s             status_i,
  input  wire logic [`MPC_IND_NUM-1:0] indicator_cfg_pin_i,
  output logic [`MPC_IND_NUM-1:0]      indicator_cfg_pin_o,
  output logic [`MPC_IND_NUM-1:0]      indicator_cfg_pin_oe_n_o,
  output logic [`MPC_IND_NUM-1:0]      cfg_strap_o,
  output logic                         cfg_valid_o,
  // test port
  input  wire logic                    tck_i,
  input  wire logic                    trst_n_i,
  input  wire logic                    tdi_i,
  input  wire logic                    tms_i,
  output logic                         tdo_o
);

  localparam int CW = $clog2(STRETCH_CYCLES + 1);

  // pick one status condition by a two-bit code
  function automatic logic pick_status(input logic [1:0] sel, input mpc_status_s st);
    case (sel)
      2'h0:    pick_status = st.link;
      2'h1:    pick_status = st.activity;
      2'h2:    pick_status = st.speed;
      default: pick_status = st.duplex;
    endcase
  endfunction

  // two-flop synchronisers for pin-level inputs
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [`MPC_IND_NUM-1:0] cfg_s1_r;
  logic [`MPC_IND_NUM-1:0] cfg_s2_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r  <= 3'h1;
      sync2_r  <= 3'h1;
      cfg_s1_r <= '0;
      cfg_s2_r <= '0;
    end else begin
      sync1_r  <= {isolate_i, powerdown_pin_i, reset_n_pin_i};
      sync2_r  <= sync1_r;
      cfg_s1_r <= indicator_cfg_pin_i;
      cfg_s2_r <= cfg_s1_r;
    end
  end

  logic rst_pin_n_s;
  logic pwrdn_s;
  logic iso_s;
  assign rst_pin_n_s = sync2_r[0];
  assign pwrdn_s     = sync2_r[1];
  assign iso_s       = sync2_r[2];

  // reset source and stretch counter
  logic [CW-1:0] stretch_r;
  logic          hard_reset_state;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stretch_r <= CW'(STRETCH_CYCLES);
    end else if (!rst_pin_n_s || soft_reset_i) begin
      stretch_r <= CW'(STRETCH_CYCLES);
    end else if (stretch_r != '0) begin
      stretch_r <= stretch_r - CW'(1);
    end
  end

  assign hard_reset_state = (stretch_r != '0);

  // mode selection; power-down pin beats everything
  mpc_mode_e mode_nxt;
  always_comb begin
    if (pwrdn_s) begin
      mode_nxt = MPC_HARD_POWERDOWN;
    end else if (hard_reset_state) begin
      mode_nxt = MPC_HARD_RESET;
    end else if (iso_s) begin
      mode_nxt = MPC_ISOLATE;
    end else if (sleep_i) begin
      mode_nxt = MPC_SLEEP;
    end else if (soft_powerdown_i) begin
      mode_nxt = MPC_SOFT_POWERDOWN;
    end else begin
      mode_nxt = MPC_NORMAL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_o <= MPC_HARD_RESET;
    end else begin
      mode_o <= mode_nxt;
    end
  end

  // pin states per mode, registered straight onto the outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mii_rx_o      <= '0;
      mii_tx_clk_o  <= 1'b1;
      mii_rx_clk_o  <= 1'b1;
      mii_out_drv_o <= '{oe_n: 1'b0, pull_dn: 1'b0};
      mii_in_drv_o  <= '{oe_n: 1'b1, pull_dn: 1'b1};
    end else begin
      case (mode_nxt)
        MPC_NORMAL: begin
          mii_rx_o      <= core_rx_i;
          mii_tx_clk_o  <= core_tx_clk_i;
          mii_rx_clk_o  <= core_rx_clk_i;
          mii_out_drv_o <= '{oe_n: 1'b0, pull_dn: 1'b0};
          mii_in_drv_o  <= '{oe_n: 1'b1, pull_dn: 1'b0};
        end
        MPC_HARD_RESET: begin
          mii_rx_o      <= '0;
          mii_tx_clk_o  <= 1'b1;
          mii_rx_clk_o  <= 1'b1;
          mii_out_drv_o <= '{oe_n: 1'b0, pull_dn: 1'b0};
          mii_in_drv_o  <= '{oe_n: 1'b1, pull_dn: 1'b1};
        end
        MPC_SOFT_POWERDOWN: begin
          mii_rx_o      <= '0;
          mii_tx_clk_o  <= core_tx_clk_i;
          mii_rx_clk_o  <= core_rx_clk_i;
          mii_out_drv_o <= '{oe_n: 1'b0, pull_dn: 1'b0};
          mii_in_drv_o  <= '{oe_n: 1'b1, pull_dn: 1'b1};
        end
        MPC_HARD_POWERDOWN: begin
          mii_rx_o      <= '0;
          mii_tx_clk_o  <= 1'b0;
          mii_rx_clk_o  <= 1'b0;
          mii_out_drv_o <= '{oe_n: 1'b1, pull_dn: 1'b0};
          mii_in_drv_o  <= '{oe_n: 1'b1, pull_dn: 1'b0};
        end
        MPC_ISOLATE: begin
          mii_rx_o      <= '0;
          mii_tx_clk_o  <= 1'b0;
          mii_rx_clk_o  <= 1'b0;
          mii_out_drv_o <= '{oe_n: 1'b1, pull_dn: 1'b1};
          mii_in_drv_o  <= '{oe_n: 1'b1, pull_dn: 1'b1};
        end
        MPC_SLEEP: begin
          mii_rx_o      <= '0;
          mii_tx_clk_o  <= 1'b0;
          mii_rx_clk_o  <= 1'b0;
          mii_out_drv_o <= '{oe_n: 1'b0, pull_dn: 1'b0};
          mii_in_drv_o  <= '{oe_n: 1'b1, pull_dn: 1'b1};
        end
        default: begin
          mii_rx_o      <= '0;
          mii_tx_clk_o  <= 1'b1;
          mii_rx_clk_o  <= 1'b1;
          mii_out_drv_o <= '{oe_n: 1'b0, pull_dn: 1'b0};
          mii_in_drv_o  <= '{oe_n: 1'b1, pull_dn: 1'b1};
        end
      endcase
    end
  end

  // strap capture: pins float as inputs through reset, latched at its end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_strap_o <= '0;
      cfg_valid_o <= 1'b0;
    end else if (hard_reset_state) begin
      cfg_strap_o <= cfg_s2_r;
      cfg_valid_o <= 1'b0;
    end else begin
      cfg_valid_o <= 1'b1;
    end
  end

  // indicator drivers, enabled only once straps are taken
  genvar g;
  generate
    for (g = 0; g < `MPC_IND_NUM; g++) begin : g_ind
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          indicator_cfg_pin_o[g]      <= 1'b0;
          indicator_cfg_pin_oe_n_o[g] <= 1'b1;
        end else begin
          indicator_cfg_pin_o[g]      <= pick_status(ind_sel_i[g*2 +: 2], status_i);
          indicator_cfg_pin_oe_n_o[g] <= hard_reset_state || pwrdn_s;
        end
      end
    end
  endgenerate

  // test shift path; tck and trst come from outside test gear
  mpc_scan_shift #(
    .LEN(SCAN_LEN)
  ) u_scan (
    .tck_i    (tck_i),
    .trst_n_i (trst_n_i),
    .tdi_i    (tdi_i),
    .shift_i  (tms_i == 1'b0),
    .tdo_o    (tdo_o)
  );

endmodule

// >>> logic/mpc_pkg.sv
package mpc_pkg;

  // pin mode for the mac-side interface
  typedef enum logic [2:0] {
    MPC_NORMAL,
    MPC_HARD_RESET,
    MPC_SOFT_POWERDOWN,
    MPC_HARD_POWERDOWN,
    MPC_ISOLATE,
    MPC_SLEEP
  } mpc_mode_e;

  // receive side group towards the mac
  typedef struct packed {
    logic [3:0] rxd;
    logic       rx_dv;
    logic       rx_er;
    logic       col;
    logic       crs;
  } mpc_rx_s;

  // per-pin drive controls: output enable low means driving
  typedef struct packed {
    logic oe_n;
    logic pull_dn;
  } mpc_drive_s;

  // status conditions available to the indicators
  typedef struct packed {
    logic link;
    logic activity;
    logic speed;
    logic duplex;
  } mpc_status_s;

endpackage

// >>> logic/mpc_scan_shift.sv
`timescale 1ns/10ps
// test shift stage: capture on rising, launch on falling edge of tck
module mpc_scan_shift #(
  parameter int LEN = 8
) (
  // test port
  input  wire logic tck_i,
  input  wire logic trst_n_i,
  input  wire logic tdi_i,
  input  wire logic shift_i,
  output logic      tdo_o
);

  logic [LEN-1:0] shift_r;

  // capture tdi on rising edge
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      shift_r <= '0;
    end else if (shift_i) begin
      shift_r <= {tdi_i, shift_r[LEN-1:1]};
    end
  end

  // launch tdo on falling edge so it is stable at the next rise
  always_ff @(negedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      tdo_o <= 1'b0;
    end else begin
      tdo_o <= shift_r[0];
    end
  end

endmodule

// >>> tb/mpc_mac_model.sv
`timescale 1ns/10ps
// mac and test-equipment stand-in
module mpc_mac_model
  import mpc_pkg::*;
(
  // bench side
  input  wire logic    clk_i,
  input  wire logic    scan_en_i,
  // mii from the phy
  input  wire mpc_rx_s mii_rx_i,
  input  wire logic    rx_clk_i,
  input  wire logic    rx_oe_n_i,
  // test port and capture
  output logic         tck_o,
  output logic         trst_n_o,
  output logic         tdi_o,
  output mpc_rx_s      rx_seen_o
);
  logic [2:0] div_r;
  initial begin
    div_r = 3'h0; tck_o = 1'b0; trst_n_o = 1'b0; tdi_o = 1'b0; rx_seen_o = 8'h00;
  end
  // a floating bus reads as the flipped last value, never as a kind zero
  always @(posedge rx_clk_i) begin
    rx_seen_o <= rx_oe_n_i ? ~rx_seen_o : mii_rx_i;
  end
  // tck stands still outside a scan session; tdi moves on the falling edge
  always @(posedge clk_i) begin
    div_r <= scan_en_i ? div_r + 3'h1 : 3'h0;
    trst_n_o <= scan_en_i;
    if (scan_en_i && div_r == 3'h3) tck_o <= 1'b1;
    if (div_r == 3'h7 || !scan_en_i) begin
      tck_o <= 1'b0;
      tdi_o <= 1'($urandom);
    end
  end
endmodule

// >>> tb/mpc_pin_ctrl_checker.sv
`timescale 1ns/10ps
`include "mpc_consts.svh"
// pin-state rules watched from the top ports only
module mpc_pin_ctrl_checker
  import mpc_pkg::*;
(
  // clock and requests
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       reset_n_pin_i,
  input wire logic       soft_reset_i,
  input wire logic       powerdown_pin_i,
  // pin outputs
  input wire mpc_rx_s    mii_rx_o,
  input wire logic       mii_tx_clk_o,
  input wire logic       mii_rx_clk_o,
  input wire mpc_drive_s mii_out_drv_o,
  input wire mpc_drive_s mii_in_drv_o,
  input wire mpc_mode_e  mode_o,
  input wire logic [`MPC_IND_NUM-1:0] indicator_cfg_pin_oe_n_o,
  input wire logic [`MPC_IND_NUM-1:0] cfg_strap_o,
  input wire logic       cfg_valid_o,
  // test port
  input wire logic       tck_i,
  input wire logic       trst_n_i,
  input wire logic       tdo_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // pin inputs need two sync flops plus the mode register
  sequence pins_quiet; (!powerdown_pin_i && reset_n_pin_i)[*4]; endsequence
  sequence pd_held; powerdown_pin_i[*5]; endsequence
  hpd_float_a: assert property (mode_o == MPC_HARD_POWERDOWN |->
    mii_out_drv_o == 2'b10 && mii_in_drv_o == 2'b10) else $error("hpd pins");
  pd_wins_a: assert property (pd_held |-> mode_o == MPC_HARD_POWERDOWN)
    else $error("pd not taken");
  // counter reloads on the sampling edge, the mode register follows one edge later
  srst_enter_a: assert property (pins_quiet ##0 soft_reset_i |-> ##2 mode_o == MPC_HARD_RESET)
    else $error("soft reset ignored");
  hrst_pins_a: assert property (mode_o == MPC_HARD_RESET |-> mii_rx_o == 8'h00
    && mii_tx_clk_o && mii_rx_clk_o && !mii_out_drv_o.oe_n) else $error("hrst pins");
  iso_float_a: assert property (mode_o == MPC_ISOLATE |-> mii_out_drv_o == 2'b11)
    else $error("iso pins");
  sleep_low_a: assert property (mode_o == MPC_SLEEP |-> mii_rx_o == 8'h00
    && !mii_tx_clk_o && !mii_rx_clk_o && !mii_out_drv_o.oe_n) else $error("sleep pins");
  spd_low_a: assert property (mode_o == MPC_SOFT_POWERDOWN |-> mii_rx_o == 8'h00
    && !mii_out_drv_o.oe_n) else $error("spd pins");
  tx_pull_a: assert property (mode_o inside {MPC_HARD_RESET, MPC_SOFT_POWERDOWN,
    MPC_ISOLATE, MPC_SLEEP} |-> mii_in_drv_o == 2'b11) else $error("tx pull");
  ind_quiet_a: assert property (!cfg_valid_o |-> &indicator_cfg_pin_oe_n_o)
    else $error("indicator drives early");
  strap_hold_a: assert property (cfg_valid_o && $past(cfg_valid_o) |-> $stable(cfg_strap_o))
    else $error("strap moved");
  // tdo may only move while tck is low
  tdo_fall_a: assert property (@(posedge clk_i) disable iff (!trst_n_i)
    $changed(tdo_o) |-> !tck_i) else $error("tdo off edge");
endmodule
bind mpc_pin_ctrl mpc_pin_ctrl_checker u_mpc_pin_ctrl_checker (.clk_i, .rst_i,
  .reset_n_pin_i, .soft_reset_i, .powerdown_pin_i, .mii_rx_o, .mii_tx_clk_o, .mii_rx_clk_o,
  .mii_out_drv_o, .mii_in_drv_o, .mode_o, .indicator_cfg_pin_oe_n_o, .cfg_strap_o,
  .cfg_valid_o, .tck_i, .trst_n_i, .tdo_o);

// >>> tb/mpc_pin_ctrl_test.sv
`timescale 1ns/10ps
`include "mpc_consts.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module mpc_pin_ctrl_test;
  import mpc_pkg::*;
  typedef struct packed { logic [1:0] k; logic [14:0] v; } mpc_note_s;
  logic clk_i = 0, rst_i = 1, rn = 1, srst = 0, pd = 0, spd = 0, iso = 0, slp = 0;
  logic ctx = 1, crx = 0, tms = 0, scan = 0, txc, rxc, cv, tck, trst_n, tdi, tdo;
  logic [5:0] sel = 6'h00;
  logic [2:0] pin_i = 3'h0, ind, ind_oe_n, strap, ind_w;
  mpc_rx_s crd = 8'h00, rxo, seen;
  mpc_status_s st = 4'h0;
  mpc_drive_s od, idr;
  mpc_mode_e mode;
  mpc_note_s q[$], nt;
  int fails = 0, n_checks = 0;
  event smp;
  always #12.5 clk_i = ~clk_i;
  // scan shadow: at a tck rise tdo shows the bit taken eight rises before
  logic [7:0] hist = 8'h00;
  always @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      hist <= 8'h00;
    end else begin
      q.push_back({2'd3, 14'h0000, hist[7]});
      ->smp;
      hist <= {hist[6:0], tdi};
    end
  end
  // indicator wire: design level where it drives, strap level otherwise
  assign ind_w = (ind_oe_n & pin_i) | (~ind_oe_n & ind);
  mpc_pin_ctrl #(.STRETCH_CYCLES(8)) u_mpc_pin_ctrl (.clk_i, .rst_i, .reset_n_pin_i(rn),
    .soft_reset_i(srst), .powerdown_pin_i(pd), .soft_powerdown_i(spd), .isolate_i(iso),
    .sleep_i(slp), .core_rx_i(crd), .core_tx_clk_i(ctx), .core_rx_clk_i(crx), .mii_rx_o(rxo),
    .mii_tx_clk_o(txc), .mii_rx_clk_o(rxc), .mii_out_drv_o(od), .mii_in_drv_o(idr),
    .mode_o(mode), .ind_sel_i(sel), .status_i(st), .indicator_cfg_pin_i(ind_w),
    .indicator_cfg_pin_o(ind), .indicator_cfg_pin_oe_n_o(ind_oe_n), .cfg_strap_o(strap),
    .cfg_valid_o(cv), .tck_i(tck), .trst_n_i(trst_n), .tdi_i(tdi), .tms_i(tms), .tdo_o(tdo));
  mpc_mac_model u_mpc_mac_model (.clk_i, .scan_en_i(scan), .mii_rx_i(rxo), .rx_clk_i(rxc),
    .rx_oe_n_i(od.oe_n), .tck_o(tck), .trst_n_o(trst_n), .tdi_o(tdi), .rx_seen_o(seen));
  // expected pins: mode, rx group, both clocks, output enable, tx pull-down
  function automatic logic [14:0] pins(mpc_mode_e m);
    case (m)
      MPC_NORMAL:         return {m, crd, ctx, crx, 2'b00};
      MPC_HARD_RESET:     return {m, 8'h00, 4'b1101};
      MPC_SOFT_POWERDOWN: return {m, 8'h00, ctx, crx, 2'b01};
      MPC_HARD_POWERDOWN: return {m, 8'h00, 4'b0010};
      MPC_ISOLATE:        return {m, 8'h00, 4'b0011};
      default:            return {m, 8'h00, 4'b0001};
    endcase
  endfunction
  task automatic conclude();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic note(logic [1:0] k, logic [14:0] v);
    q.push_back({k, v});
    ->smp;
    @(negedge clk_i);
  endtask
  // bounded wait; running out counts as a mismatch
  task automatic wait_mode(mpc_mode_e m);
    for (int i = 0; i < 60 && mode !== m; i++) @(negedge clk_i);
    if (mode !== m) begin
      fails++;
      conclude();
    end
  endtask
  // pin inputs settle within five cycles through their sync flops
  task automatic go(logic [4:0] r, mpc_mode_e m);
    {pd, srst, iso, slp, spd} = r;
    repeat (5) @(negedge clk_i);
    note(2'd0, pins(m));
  endtask
  // watcher takes the oldest note whenever the driver flags a settled result
  always @(smp) begin
    nt = q.pop_front();
    case (nt.k)
      2'd0: `CHK("pins", nt.v, {mode, rxo, txc, rxc, od.oe_n, idr.pull_dn})
      2'd1: `CHK("strap", nt.v[2:0], strap)
      2'd3: `CHK("tdo", nt.v[0], tdo)
      default: `CHK("ind", nt.v[5:0], {ind_oe_n, ind})
    endcase
  end
  initial begin
    void'($urandom(86));
    crd = 8'($urandom);
    pin_i = 3'($urandom);
    repeat (5) @(negedge clk_i);
    rst_i = 0;
    wait_mode(MPC_NORMAL);
    note(2'd1, {12'h000, pin_i});
    for (int i = 0; i < 4; i++) begin
      sel = {2'(i + 2), 2'(i + 1), 2'(i)};
      st = 4'($urandom);
      crd = 8'($urandom);
      repeat (4) @(negedge clk_i);
      note(2'd2, {12'h000, st[3 - (i + 2) % 4], st[3 - (i + 1) % 4], st[3 - i % 4]});
      note(2'd0, pins(MPC_NORMAL));
    end
    go(5'b00010, MPC_SLEEP);
    go(5'b00001, MPC_SOFT_POWERDOWN);
    go(5'b00011, MPC_SLEEP);
    go(5'b00111, MPC_ISOLATE);
    go(5'b10100, MPC_HARD_POWERDOWN);
    go(5'b01100, MPC_HARD_RESET);
    go(5'b11000, MPC_HARD_POWERDOWN);
    go(5'b00000, MPC_HARD_RESET);
    wait_mode(MPC_NORMAL);
    rn = 0;
    repeat (4) @(negedge clk_i);
    rn = 1;
    repeat (8) note(2'd0, pins(MPC_HARD_RESET));
    wait_mode(MPC_NORMAL);
    scan = 1;
    repeat (160) @(negedge clk_i);
    scan = 0;
    conclude();
  end
endmodule
